// file: hdl/bounds_decode_cfg.svh
// Functional notes
// - Bounds check word: 00000, size, 0, 11, ea
// - Bounds size 00 byte, 01 word, 10 long
// - Bounds operands use control addressing modes only
// - Reject register, postinc, predec, immediate bounds modes
// - Extension top bit selects data/address register
// - Extension register field; bit 11 one, rest zero
// - Clear writes zero; sizes 00, 01, 10
// - Clear destination must be data alterable
// - Early parts read memory before clearing it
// - Compare subtracts source, flags only, register kept
// - Compare NZVC from result, X kept
// - Compare register field, opmode 000/001/010 sizes
// - Out of bounds raises trap vector six
// - Lower then upper; sign-extend for address registers
// - Bounds Z on equal, C on out of bounds
`ifndef BOUNDS_DECODE_CFG_SVH
`define BOUNDS_DECODE_CFG_SVH

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define BND_OP_MASK 16'hF9C0
`define BND_OP_VALUE 16'h00C0
`define BND_EXT_MASK 16'h0FFF
`define BND_EXT_VALUE 16'h0800
`define ZERO_OP_MASK 16'hFF00
`define ZERO_OP_VALUE 16'h4200
`define COMPARE_OP_MASK 16'hF000
`define COMPARE_OP_VALUE 16'hB000

// ****************************************************************
// Field positions
// ****************************************************************
`define SIZE_HI 7
`define SIZE_LO 6
`define BND_SIZE_HI 10
`define BND_SIZE_LO 9
`define OPMODE_HI 8
`define OPMODE_LO 6
`define DREG_HI 11
`define DREG_LO 9
`define EA_MODE_HI 5
`define EA_MODE_LO 3
`define EA_REG_HI 2
`define EA_REG_LO 0
`define EXT_DA_BIT 15
`define EXT_REG_HI 14
`define EXT_REG_LO 12

// ****************************************************************
// Addressing mode codes
// ****************************************************************
`define MODE_DREG 3'h0
`define MODE_AREG 3'h1
`define MODE_IND 3'h2
`define MODE_POSTINC 3'h3
`define MODE_PREDEC 3'h4
`define MODE_DISP 3'h5
`define MODE_INDEX 3'h6
`define MODE_EXT 3'h7
`define EXT_ABS_W 3'h0
`define EXT_ABS_L 3'h1
`define EXT_PC_DISP 3'h2
`define EXT_PC_INDEX 3'h3

// ****************************************************************
// Condition flags and trap
// ****************************************************************
`define CC_X 4
`define CC_N 3
`define CC_Z 2
`define CC_V 1
`define CC_C 0
`define BOUNDS_VECTOR 8'h06

`endif

// file: hdl/bounds_decode_pkg.sv
package bounds_decode_pkg;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2,
    SZ_BAD = 2'h3
  } size_e;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_BOUNDS = 2'h1,
    OP_ZERO = 2'h2,
    OP_COMPARE = 2'h3
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOWER = 2'b01,
    ST_UPPER = 2'b11,
    ST_READ = 2'b10
  } state_e;
endpackage

// file: hdl/compare_alu_if.sv
`timescale 1ns/1ps
interface compare_alu_if;
  logic [31:0] dst;
  logic [31:0] src;
  bounds_decode_pkg::size_e size;
  logic n;
  logic z;
  logic v;
  logic c;

  modport alu (input dst, input src, input size,
    output n, output z, output v, output c);
  modport user (output dst, output src, output size,
    input n, input z, input v, input c);
endinterface

// file: hdl/compare_alu.sv
`timescale 1ns/1ps
`include "bounds_decode_cfg.svh"
module compare_alu (
  // Operands and flags
  compare_alu_if.alu port
);
  logic [31:0] mask;
  logic [32:0] diff;
  logic [31:0] res;
  logic sd;
  logic ss;
  logic sr;

  assign mask = (port.size == bounds_decode_pkg::SZ_BYTE) ? 32'h000000FF :
                (port.size == bounds_decode_pkg::SZ_WORD) ? 32'h0000FFFF :
                32'hFFFFFFFF;
  // Borrow taken at the operation width, not always at bit 31
  assign diff = {1'b0, port.dst & mask} - {1'b0, port.src & mask};
  assign res = diff[31:0] & mask;

  function automatic logic top_bit(input logic [31:0] v,
                                   input bounds_decode_pkg::size_e s);
    case (s)
      bounds_decode_pkg::SZ_BYTE: top_bit = v[7];
      bounds_decode_pkg::SZ_WORD: top_bit = v[15];
      default: top_bit = v[31];
    endcase
  endfunction

  assign sd = top_bit(port.dst, port.size);
  assign ss = top_bit(port.src, port.size);
  assign sr = top_bit(res, port.size);

  assign port.n = sr;
  assign port.z = (res == 32'h00000000);
  assign port.v = (sd != ss) && (sr != sd);
  assign port.c = diff[32];
endmodule

// file: hdl/bounds_clear_compare_decode.sv
`timescale 1ns/1ps
`include "bounds_decode_cfg.svh"
module bounds_clear_compare_decode #(
  parameter bit READ_BEFORE_CLEAR = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Instruction issue
  input wire logic start,
  input wire logic [15:0] opWord,
  input wire logic [15:0] extWord,
  input wire logic [31:0] regValue,
  input wire logic [31:0] srcOperand,
  input wire logic [4:0] ccrIn,
  // Memory operand return
  input wire logic memValid,
  input wire logic [31:0] memData,
  // Handshake
  output logic busy,
  output logic fetchLower,
  output logic fetchUpper,
  output logic readDest,
  // Completion
  output logic done,
  output logic illegal,
  output logic boundsTrap,
  output logic [7:0] trapVector,
  output logic [4:0] ccrOut,
  output logic ccrWrite,
  output logic [31:0] result,
  output logic resultWrite,
  output logic [2:0] regNum,
  output logic regIsAddr,
  output logic [1:0] opSize,
  output logic [1:0] opKind
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  logic [2:0] eaMode;
  logic [2:0] eaReg;
  logic [2:0] opmode;
  logic isBounds;
  logic isZero;
  logic isCompare;
  logic boundsOk;
  logic zeroOk;
  logic compareOk;
  logic decodeBad;
  logic needRead;
  bounds_decode_pkg::size_e bndSize;
  bounds_decode_pkg::size_e zeroSize;
  bounds_decode_pkg::size_e cmpSize;

  function automatic logic control_mode(input logic [2:0] m,
                                        input logic [2:0] r);
    control_mode = (m == `MODE_IND) || (m == `MODE_DISP) ||
                   (m == `MODE_INDEX) ||
                   ((m == `MODE_EXT) && ((r == `EXT_ABS_W) ||
                    (r == `EXT_ABS_L) || (r == `EXT_PC_DISP) ||
                    (r == `EXT_PC_INDEX)));
  endfunction

  function automatic logic data_alterable(input logic [2:0] m,
                                          input logic [2:0] r);
    data_alterable = (m != `MODE_AREG) && ((m != `MODE_EXT) ||
                     (r == `EXT_ABS_W) || (r == `EXT_ABS_L));
  endfunction

  assign eaMode = opWord[`EA_MODE_HI:`EA_MODE_LO];
  assign eaReg = opWord[`EA_REG_HI:`EA_REG_LO];
  assign opmode = opWord[`OPMODE_HI:`OPMODE_LO];
  assign isBounds = (opWord & `BND_OP_MASK) == `BND_OP_VALUE;
  assign isZero = (opWord & `ZERO_OP_MASK) == `ZERO_OP_VALUE;
  assign isCompare =
    (opWord & `COMPARE_OP_MASK) == `COMPARE_OP_VALUE;
  assign bndSize = bounds_decode_pkg::size_e'(
    opWord[`BND_SIZE_HI:`BND_SIZE_LO]);
  assign zeroSize = bounds_decode_pkg::size_e'(
    opWord[`SIZE_HI:`SIZE_LO]);
  assign cmpSize = bounds_decode_pkg::size_e'(opmode[1:0]);
  // Control modes exclude register, postinc, predec, immediate
  assign boundsOk = (bndSize != bounds_decode_pkg::SZ_BAD) &&
    control_mode(eaMode, eaReg) &&
    ((extWord & `BND_EXT_MASK) == `BND_EXT_VALUE);
  assign zeroOk = (zeroSize != bounds_decode_pkg::SZ_BAD) &&
    data_alterable(eaMode, eaReg);
  // Opmodes with bit 8 set or 011 belong to other compare forms
  assign compareOk = !opmode[2] &&
    (opmode[1:0] != 2'h3) &&
    !((cmpSize == bounds_decode_pkg::SZ_BYTE) &&
      (eaMode == `MODE_AREG));
  assign decodeBad = !((isBounds && boundsOk) ||
    (isZero && zeroOk) || (isCompare && compareOk));
  assign needRead = READ_BEFORE_CLEAR &&
    (eaMode != `MODE_DREG);

  // ****************************************************************
  // Flag arithmetic
  // ****************************************************************
  compare_alu_if alu ();
  compare_alu u_alu (
    .port(alu)
  );
  assign alu.dst = regValue;
  assign alu.src = srcOperand;
  assign alu.size = cmpSize;

  bounds_decode_pkg::state_e state_reg;
  bounds_decode_pkg::state_e state_next;
  bounds_decode_pkg::size_e size_reg;
  logic [31:0] checked_reg;
  logic [31:0] lower_reg;
  logic [31:0] checked_next;
  logic [31:0] lower_next;
  logic addr_reg;
  logic addr_next;
  logic xFlag_reg;
  logic xFlag_next;

  // Data registers keep their low part only; address bounds widen
  function automatic logic [31:0] widen(input logic [31:0] v,
                                        input bounds_decode_pkg::size_e s,
                                        input logic sx);
    case (s)
      bounds_decode_pkg::SZ_BYTE: widen = {{24{sx & v[7]}}, v[7:0]};
      bounds_decode_pkg::SZ_WORD: widen = {{16{sx & v[15]}}, v[15:0]};
      default: widen = v;
    endcase
  endfunction

  logic [31:0] lbWide;
  logic [31:0] ubWide;
  logic [31:0] rvWide;
  logic outOfRange;
  logic onBound;

  assign lbWide = widen(lower_reg, size_reg, addr_reg);
  assign ubWide = widen(memData, size_reg, addr_reg);
  assign rvWide = addr_reg ? checked_reg :
    widen(checked_reg, size_reg, 1'b0);
  // A pair with lower above upper is a wrapped range, which makes
  // one unsigned test serve both signed and unsigned bound pairs
  assign outOfRange = (lbWide <= ubWide) ?
    ((rvWide < lbWide) || (rvWide > ubWide)) :
    ((rvWide < lbWide) && (rvWide > ubWide));
  assign onBound = (rvWide == lbWide) || (rvWide == ubWide);

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  logic done_next;
  logic illegal_next;
  logic trap_next;
  logic [4:0] ccr_next;
  logic ccrWrite_next;
  logic resWrite_next;
  logic [2:0] regNum_next;
  logic regIsAddr_next;
  logic [1:0] opSize_next;
  logic [1:0] opKind_next;
  logic accept;

  assign busy = (state_reg != bounds_decode_pkg::ST_IDLE);
  assign accept = start && !busy;
  assign fetchLower = (state_reg == bounds_decode_pkg::ST_LOWER);
  assign fetchUpper = (state_reg == bounds_decode_pkg::ST_UPPER);
  assign readDest = (state_reg == bounds_decode_pkg::ST_READ);

  always_comb begin
    state_next = state_reg;
    checked_next = checked_reg;
    lower_next = lower_reg;
    addr_next = addr_reg;
    xFlag_next = xFlag_reg;
    done_next = 1'b0;
    illegal_next = illegal;
    trap_next = boundsTrap;
    ccr_next = ccrOut;
    ccrWrite_next = 1'b0;
    resWrite_next = 1'b0;
    regNum_next = regNum;
    regIsAddr_next = regIsAddr;
    opSize_next = opSize;
    opKind_next = opKind;
    case (state_reg)
      bounds_decode_pkg::ST_IDLE: begin
        if (accept) begin
          xFlag_next = ccrIn[`CC_X];
          illegal_next = decodeBad;
          trap_next = 1'b0;
          done_next = 1'b1;
          if (decodeBad) begin
            opKind_next = bounds_decode_pkg::OP_NONE;
          end else if (isBounds) begin
            done_next = 1'b0;
            opKind_next = bounds_decode_pkg::OP_BOUNDS;
            opSize_next = bndSize;
            addr_next = extWord[`EXT_DA_BIT];
            regIsAddr_next = extWord[`EXT_DA_BIT];
            regNum_next = extWord[`EXT_REG_HI:`EXT_REG_LO];
            checked_next = regValue;
            state_next = bounds_decode_pkg::ST_LOWER;
          end else if (isZero) begin
            opKind_next = bounds_decode_pkg::OP_ZERO;
            opSize_next = zeroSize;
            regIsAddr_next = 1'b0;
            regNum_next = eaReg;
            if (needRead) begin
              done_next = 1'b0;
              state_next = bounds_decode_pkg::ST_READ;
            end else begin
              resWrite_next = 1'b1;
              ccrWrite_next = 1'b1;
              ccr_next = {ccrIn[`CC_X], 4'h4};
            end
          end else begin
            opKind_next = bounds_decode_pkg::OP_COMPARE;
            opSize_next = cmpSize;
            regIsAddr_next = 1'b0;
            regNum_next = opWord[`DREG_HI:`DREG_LO];
            ccrWrite_next = 1'b1;
            ccr_next = {ccrIn[`CC_X], alu.n, alu.z,
                        alu.v, alu.c};
          end
        end
      end
      bounds_decode_pkg::ST_LOWER: begin
        if (memValid) begin
          lower_next = memData;
          state_next = bounds_decode_pkg::ST_UPPER;
        end
      end
      bounds_decode_pkg::ST_UPPER: begin
        if (memValid) begin
          done_next = 1'b1;
          ccrWrite_next = 1'b1;
          trap_next = outOfRange;
          // N and V are left as they were, as they carry no meaning
          ccr_next = {xFlag_reg, ccrOut[`CC_N], onBound,
                      ccrOut[`CC_V], outOfRange};
          state_next = bounds_decode_pkg::ST_IDLE;
        end
      end
      bounds_decode_pkg::ST_READ: begin
        if (memValid) begin
          done_next = 1'b1;
          resWrite_next = 1'b1;
          ccrWrite_next = 1'b1;
          ccr_next = {xFlag_reg, 4'h4};
          state_next = bounds_decode_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = bounds_decode_pkg::ST_IDLE;
      end
    endcase
  end

  assign trapVector = boundsTrap ? `BOUNDS_VECTOR : 8'h00;
  assign result = 32'h00000000;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= bounds_decode_pkg::ST_IDLE;
      size_reg <= bounds_decode_pkg::SZ_BYTE;
      checked_reg <= 32'h00000000;
      lower_reg <= 32'h00000000;
      addr_reg <= 1'b0;
      xFlag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      size_reg <= bounds_decode_pkg::size_e'(opSize_next);
      checked_reg <= checked_next;
      lower_reg <= lower_next;
      addr_reg <= addr_next;
      xFlag_reg <= xFlag_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      illegal <= 1'b0;
      boundsTrap <= 1'b0;
      ccrOut <= 5'h00;
      ccrWrite <= 1'b0;
      resultWrite <= 1'b0;
      regNum <= 3'h0;
      regIsAddr <= 1'b0;
      opSize <= 2'h0;
      opKind <= 2'h0;
    end else begin
      done <= done_next;
      illegal <= illegal_next;
      boundsTrap <= trap_next;
      ccrOut <= ccr_next;
      ccrWrite <= ccrWrite_next;
      resultWrite <= resWrite_next;
      regNum <= regNum_next;
      regIsAddr <= regIsAddr_next;
      opSize <= opSize_next;
      opKind <= opKind_next;
    end
  end
endmodule

// file: tb/bounds_clear_compare_decode_sva.sv
`timescale 1ns/1ps
module bounds_clear_compare_decode_sva #(
  parameter bit READ_BEFORE_CLEAR = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Issue
  input wire logic start,
  input wire logic [15:0] opWord,
  input wire logic [15:0] extWord,
  input wire logic [4:0] ccrIn,
  input wire logic memValid,
  // Outcome
  input wire logic busy,
  input wire logic fetchLower,
  input wire logic fetchUpper,
  input wire logic readDest,
  input wire logic done,
  input wire logic illegal,
  input wire logic boundsTrap,
  input wire logic [7:0] trapVector,
  input wire logic [4:0] ccrOut,
  input wire logic ccrWrite,
  input wire logic [31:0] result,
  input wire logic resultWrite,
  input wire logic [1:0] opKind
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  wire logic accept = start && !busy;

  sequence s_lower_taken;
    fetchLower && memValid;
  endsequence
  sequence s_upper_taken;
    fetchUpper && memValid;
  endsequence
  sequence s_dest_taken;
    readDest && memValid;
  endsequence

  a_compare_one_cycle: assert property (
    accept && opWord[15:12] == 4'hB |=> done)
    else $error("compare did not finish after one cycle");
  a_clear_flags: assert property (
    done && resultWrite |-> ccrWrite && ccrOut[3:0] == 4'h4)
    else $error("clear flags wrong");
  a_clear_extend_kept: assert property (
    accept && opWord[15:8] == 8'h42 && opWord[5:3] == 3'h0
    |=> illegal || (resultWrite && ccrOut[4] == $past(ccrIn[4])))
    else $error("clear lost extend flag or write");
  a_zero_result: assert property (
    resultWrite |-> result == 32'h0)
    else $error("clear data not zero");
  a_trap_vector: assert property (
    trapVector == (boundsTrap ? 8'h06 : 8'h00))
    else $error("trap vector wrong");
  a_bounds_fetch_first: assert property (
    accept && opWord[15:11] == 5'h0 && opWord[8:6] == 3'h3
    && opWord[10:9] != 2'h3 && opWord[5:3] == 3'h2
    && extWord[11:0] == 12'h800
    |=> busy && fetchLower)
    else $error("bounds check did not fetch lower bound");
  a_lower_then_upper: assert property (
    s_lower_taken |=> fetchUpper && !fetchLower && !done)
    else $error("upper bound not requested after lower");
  a_upper_then_done: assert property (
    s_upper_taken |=> done && ccrWrite && !busy && ccrOut[0] == boundsTrap)
    else $error("bounds check completion wrong");
  a_illegal_quiet: assert property (
    done && illegal |-> !ccrWrite && !resultWrite && opKind == 2'h0)
    else $error("illegal encoding had side effects");
  a_pre_read_wait: assert property (
    accept && READ_BEFORE_CLEAR && opWord[15:8] == 8'h42
    && opWord[7:6] != 2'h3 && opWord[5:3] == 3'h2
    |=> busy && readDest && !done)
    else $error("clear did not wait for destination read");
  a_pre_read_done: assert property (
    s_dest_taken |=> done && resultWrite && ccrWrite && !readDest)
    else $error("clear pre-read did not complete");
endmodule

bind bounds_clear_compare_decode bounds_clear_compare_decode_sva #(
  .READ_BEFORE_CLEAR(READ_BEFORE_CLEAR)
) u_chk (.clk_sys, .rst_n, .start, .opWord, .extWord, .ccrIn, .memValid,
  .busy, .fetchLower, .fetchUpper, .readDest, .done, .illegal,
  .boundsTrap, .trapVector,
  .ccrOut, .ccrWrite, .result, .resultWrite, .opKind);

// file: tb/bounds_clear_compare_decode_bench.sv
`timescale 1ns/1ps
module bounds_clear_compare_decode_bench;
  logic clk_sys, rst_n, start, memValid, busy, fetchLower, fetchUpper;
  logic readDest, done, illegal, boundsTrap, ccrWrite, resultWrite;
  logic regIsAddr;
  logic [15:0] opWord, extWord;
  logic [31:0] regValue, srcOperand, memData, result;
  logic [4:0] ccrIn, ccrOut;
  logic [7:0] trapVector;
  logic [2:0] regNum;
  logic [1:0] opSize, opKind;
  logic preBusy, preReadDest, preDone, preResultWrite, preCcrWrite;
  logic [4:0] preCcrOut;
  int n_mismatch, n_compared, cycles;

  bounds_clear_compare_decode dut (.clk_sys, .rst_n, .start, .opWord,
    .extWord, .regValue, .srcOperand, .ccrIn, .memValid, .memData, .busy,
    .fetchLower, .fetchUpper, .readDest, .done, .illegal, .boundsTrap,
    .trapVector, .ccrOut, .ccrWrite, .result, .resultWrite, .regNum,
    .regIsAddr, .opSize, .opKind);

  // Early-part variant shares all stimulus with the plain instance
  bounds_clear_compare_decode #(.READ_BEFORE_CLEAR(1'b1)) dutRead (
    .clk_sys, .rst_n, .start, .opWord, .extWord, .regValue, .srcOperand,
    .ccrIn, .memValid, .memData, .busy(preBusy), .fetchLower(),
    .fetchUpper(), .readDest(preReadDest), .done(preDone), .illegal(),
    .boundsTrap(), .trapVector(), .ccrOut(preCcrOut),
    .ccrWrite(preCcrWrite), .result(), .resultWrite(preResultWrite),
    .regNum(), .regIsAddr(), .opSize(), .opKind());

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want,
                     input string what);
    n_compared++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  // Start is taken at the edge after it is raised; ends mid-cycle
  task automatic issue(input logic [15:0] op, input logic [15:0] ext,
                       input logic [31:0] rv, input logic [31:0] sv,
                       input logic [4:0] cc);
    @(posedge clk_sys);
    start <= 1'b1;
    opWord <= op;
    extWord <= ext;
    regValue <= rv;
    srcOperand <= sv;
    ccrIn <= cc;
    @(posedge clk_sys);
    start <= 1'b0;
    @(negedge clk_sys);
  endtask

  // Data bus is scrambled once the beat is over
  task automatic feed(input logic [31:0] d);
    @(posedge clk_sys);
    memValid <= 1'b1;
    memData <= d;
    @(posedge clk_sys);
    memValid <= 1'b0;
    memData <= ~d;
    @(negedge clk_sys);
  endtask

  function automatic logic [3:0] nzvc(input logic [31:0] d,
                                      input logic [31:0] s, input int w);
    logic [31:0] m;
    logic [31:0] r;
    m = (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
    r = (d & m) - (s & m);
    return {r[w-1], (r & m) == 32'h0,
            (d[w-1] != s[w-1]) && (r[w-1] != d[w-1]), (s & m) > (d & m)};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_compare();
    logic [31:0] dv [3] = '{32'h80, 32'h0, 32'h12345678};
    logic [31:0] sv [3] = '{32'h1, 32'h1, 32'h12345678};
    logic [1:0] sz;
    for (int s = 0; s < 3; s++) begin
      for (int i = 0; i < 3; i++) begin
        sz = 2'(s);
        issue({4'hB, 3'h5, 1'b0, sz, 6'h01}, 16'h0, dv[i], sv[i], 5'h10);
        chk({done, ccrOut, ccrWrite, resultWrite, opKind, opSize, regNum},
            {2'h3, nzvc(dv[i], sv[i], 8 << s), 2'h2, 2'h3, sz, 3'h5},
            "compare");
      end
    end
  endtask

  task automatic t_clear();
    logic [4:0] cc [2] = '{5'h1F, 5'h0E};
    logic [1:0] sz;
    for (int s = 0; s < 3; s++) begin
      for (int i = 0; i < 2; i++) begin
        sz = 2'(s);
        issue({8'h42, sz, 6'h03}, 16'h0, 32'h0, 32'h0, cc[i]);
        chk({done, ccrOut, ccrWrite, resultWrite, opKind, opSize, regNum},
            {1'b1, cc[i][4], 4'h4, 2'h3, 2'h2, sz, 3'h3},
            "clear");
        chk(result, 32'h0, "clear data");
        chk({preDone, preReadDest}, 2'h2, "register clear read");
      end
    end
  endtask

  task automatic t_illegal();
    logic [15:0] op [14] = '{16'h42C0, 16'h4208, 16'h423A, 16'h423C,
      16'hB0C1, 16'h00C0, 16'h00C8, 16'h00D8, 16'h00E0, 16'h00FC,
      16'h06D0, 16'h00E8, 16'hB008, 16'hB140};
    for (int i = 0; i < 14; i++) begin
      issue(op[i], (i == 11) ? 16'h0801 : 16'h0800, 32'h0, 32'h0, 5'h0);
      chk({done, illegal, ccrWrite, resultWrite, opKind, busy}, 7'h60,
          "illegal");
    end
  endtask

  task automatic t_bounds();
    logic [15:0] op [7] = '{16'h00D2, 16'h02E9, 16'h04F8, 16'h02F3,
      16'h02FB, 16'h04F9, 16'h00FA};
    logic [15:0] ex [7] = '{16'h4800, 16'h2800, 16'h1800, 16'hE800,
      16'hE800, 16'h9800, 16'hF800};
    logic [31:0] rv [7] = '{32'hAB55, 32'h12340010, 32'h101, 32'hFFFFFFF8,
      32'hFFF8, 32'h80000000, 32'hFFFFFF80};
    logic [31:0] lo [7] = '{32'hFFFFFF10, 32'h10, 32'h10, 32'h1234FFF0,
      32'hFFF0, 32'h80000000, 32'h80};
    logic [31:0] up [7] = '{32'h60, 32'h100, 32'h100, 32'h10, 32'h10,
      32'h80000010, 32'h7F};
    logic [1:0] zc [7] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2};
    for (int i = 0; i < 7; i++) begin
      issue(op[i], ex[i], rv[i], 32'h0, 5'h10);
      chk({busy, fetchLower, fetchUpper}, 3'h6, "lower wait");
      // A second request while busy must be ignored silently
      @(posedge clk_sys);
      start <= 1'b1;
      opWord <= 16'hB001;
      @(posedge clk_sys);
      start <= 1'b0;
      feed(lo[i]);
      chk({busy, fetchLower, fetchUpper}, 3'h5, "upper wait");
      feed(up[i]);
      chk({done, ccrWrite, busy, boundsTrap, trapVector},
          {3'h6, zc[i][0], (zc[i][0] ? 8'h06 : 8'h00)},
          "trap");
      chk({ccrOut[4], ccrOut[2], ccrOut[0]}, {1'b1, zc[i]},
          "bounds flags");
      chk({regIsAddr, regNum, opSize, opKind},
          {ex[i][15:12], op[i][10:9], 2'h1}, "bounds fields");
    end
  endtask

  // Only the early-part instance reads a memory destination first
  task automatic t_pre_read();
    issue(16'h4292, 16'h0, 32'h0, 32'h0, 5'h1F);
    chk({done, resultWrite, readDest, preDone, preReadDest, preBusy},
        6'h33, "pre-read wait");
    feed(32'hA5A5A5A5);
    chk({preDone, preResultWrite, preCcrWrite, preReadDest, preBusy,
         preCcrOut}, {5'h1C, 5'h14}, "pre-read done");
  endtask

  // ****************************************************************
  // Run
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    opWord = 16'h0;
    extWord = 16'h0;
    regValue = 32'h0;
    srcOperand = 32'h0;
    ccrIn = 5'h0;
    memValid = 1'b0;
    memData = 32'h0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_compare();
    t_clear();
    t_illegal();
    t_bounds();
    t_pre_read();
    summarize();
  end
endmodule
